// file: mic_pkg.sv
// Constants shared by the interrupt controller: register indices, field
// positions, reset values, vectors and bus responses.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package mic_pkg;

	localparam int ADDR_W = 12;
	localparam int VEC_W  = 11;

	// Register indices; byte address is four times the index
	localparam logic [7:0] REG_A_IDX     = 8'h0B;
	localparam logic [7:0] REG_B_IDX     = 8'h1E;
	localparam logic [7:0] IRQ_STAT_IDX  = 8'h30;
	localparam logic [7:0] IRQ_MASK_IDX  = 8'h31;
	localparam logic [7:0] CORE_STAT_IDX = 8'h32;

	// Control register A fields
	localparam int A_GIE      = 0;
	localparam int A_EXT_EN   = 1;
	localparam int A_TMR_EN   = 2;
	localparam int A_ADC_EN   = 3;
	localparam int A_EXT_FLAG = 4;
	localparam int A_TMR_FLAG = 5;
	localparam int A_ADC_FLAG = 6;

	// Control register B fields, other bits read as zero
	localparam int B_BUS_EN   = 0;
	localparam int B_BUS_FLAG = 4;
	localparam logic [7:0] REG_B_USED = 8'h11;

	// Interrupt status bits
	localparam int ST_ACK   = 0;
	localparam int ST_STALL = 1;
	localparam int ST_EDGE  = 2;
	localparam int ST_BUS   = 3;

	localparam logic [7:0] REG_A_RST = 8'h00;
	localparam logic [7:0] REG_B_RST = 8'h00;
	localparam logic [3:0] MASK_RST  = 4'h0;

	// Service vectors, in priority order
	localparam logic [10:0] VEC_EXT = 11'h004;
	localparam logic [10:0] VEC_TMR = 11'h008;
	localparam logic [10:0] VEC_ADC = 11'h00C;
	localparam logic [10:0] VEC_BUS = 11'h010;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Byte address of a register index
	function automatic logic [ADDR_W-1:0] mic_addr(input logic [7:0] idx);
		mic_addr = {2'h0, idx, 2'h0};
	endfunction

	// One-hot of the lowest set request; bit 0 has the highest priority
	function automatic logic [3:0] mic_pick(input logic [3:0] r);
		mic_pick = r & (4'(~r) + 4'h1);
	endfunction

endpackage

// file: mic_intc.sv
// Four-source vectored interrupt controller with AXI4-Lite registers.
// Assumes the core pulses phase_two_pulse once per instruction cycle and
// reports its return-stack level; peripheral events are one-cycle pulses.
// Operation
// - Taking any interrupt clears global enable
// - No acknowledge while return stack full
// - Acknowledge pushes program counter only, then branches
// - Falling external pin sets external flag
// - External service: vector 04H, clear flag, enable
// - Timer overflow flag; vector 08H on service
// - Converter done flag; vector 0CH on service
// - Bus event flag; vector 10H on service
// - Interrupt return sets enable; plain return not
// - Requests sampled once per phase-two pulse
// - Fixed priority: external, timer, converter, bus
// - Register A enable bits zero to three
// - Every source can wake halted core
// - Register B: enable bit 0, flag bit 4
// - Flags stay set until serviced or cleared
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
module mic_intc #(
	parameter int STACK_DEPTH = 6
) (
	input  wire logic                      clock,
	input  wire logic                      rst,
	input  wire logic [mic_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [mic_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	input  wire logic                      ext_irq_pin_n,
	input  wire logic                      timer_overflow,
	input  wire logic                      adc_done,
	input  wire logic                      addr_match_flag,
	input  wire logic                      bus_byte_done,
	input  wire logic                      phase_two_pulse,
	input  wire logic [2:0]                stack_level_index,
	input  wire logic                      irq_exit_reenable,
	input  wire logic                      subroutine_exit,
	output logic                           irq_ack,
	output logic [mic_pkg::VEC_W-1:0]      irq_vector,
	output logic                           wake_req,
	output logic                           irq
);

	logic [7:0]  irq_ctrl_reg_a;
	logic [7:0]  irq_ctrl_reg_b;
	logic [3:0]  irq_stat;
	logic [3:0]  irq_mask;
	logic        ext_sync1, ext_sync2, ext_prev;
	logic        ext_edge, bus_evt;
	logic [3:0]  req, win;
	logic        stack_full, take, stall;
	logic [mic_pkg::ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic        wr_do, wr_a, wr_b, wr_mask;
	logic        rd_take, rd_clr_stat;
	logic [31:0] next_rdata;
	logic        next_rd_ok;

	// Pin passes two flops; the edge is seen on the synchronised copy only
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ext_sync1 <= 1'b1;
			ext_sync2 <= 1'b1;
			ext_prev  <= 1'b1;
		end else begin
			ext_sync1 <= ext_irq_pin_n;
			ext_sync2 <= ext_sync1;
			ext_prev  <= ext_sync2;
		end
	end

	assign ext_edge = ext_prev & ~ext_sync2;
	assign bus_evt  = addr_match_flag | bus_byte_done;

	// Pending and enabled requests in priority order
	assign req[0] = irq_ctrl_reg_a[mic_pkg::A_EXT_FLAG] & irq_ctrl_reg_a[mic_pkg::A_EXT_EN];
	assign req[1] = irq_ctrl_reg_a[mic_pkg::A_TMR_FLAG] & irq_ctrl_reg_a[mic_pkg::A_TMR_EN];
	assign req[2] = irq_ctrl_reg_a[mic_pkg::A_ADC_FLAG] & irq_ctrl_reg_a[mic_pkg::A_ADC_EN];
	assign req[3] = irq_ctrl_reg_b[mic_pkg::B_BUS_FLAG] & irq_ctrl_reg_b[mic_pkg::B_BUS_EN];
	assign win    = mic_pkg::mic_pick(req);

	// Decision only at the phase-two pulse, so a request waits for the next one
	assign stack_full = stack_level_index >= 3'(STACK_DEPTH);
	assign take  = phase_two_pulse & irq_ctrl_reg_a[mic_pkg::A_GIE] & (|req) & ~stack_full;
	assign stall = phase_two_pulse & irq_ctrl_reg_a[mic_pkg::A_GIE] & (|req) & stack_full;

	// Control register A: write, service clears, return, then events win last
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_ctrl_reg_a <= mic_pkg::REG_A_RST;
		end else begin
			if (wr_a) begin
				irq_ctrl_reg_a <= wr_data[7:0];
			end
			if (take) begin
				irq_ctrl_reg_a[mic_pkg::A_GIE] <= 1'b0;
				if (win[0]) begin
					irq_ctrl_reg_a[mic_pkg::A_EXT_FLAG] <= 1'b0;
				end
				if (win[1]) begin
					irq_ctrl_reg_a[mic_pkg::A_TMR_FLAG] <= 1'b0;
				end
				if (win[2]) begin
					irq_ctrl_reg_a[mic_pkg::A_ADC_FLAG] <= 1'b0;
				end
			end
			if (irq_exit_reenable) begin
				irq_ctrl_reg_a[mic_pkg::A_GIE] <= 1'b1;
			end
			if (ext_edge) begin
				irq_ctrl_reg_a[mic_pkg::A_EXT_FLAG] <= 1'b1;
			end
			if (timer_overflow) begin
				irq_ctrl_reg_a[mic_pkg::A_TMR_FLAG] <= 1'b1;
			end
			if (adc_done) begin
				irq_ctrl_reg_a[mic_pkg::A_ADC_FLAG] <= 1'b1;
			end
		end
	end

	// Control register B holds only its two live bits
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_ctrl_reg_b <= mic_pkg::REG_B_RST;
		end else begin
			if (wr_b) begin
				irq_ctrl_reg_b <= wr_data[7:0] & mic_pkg::REG_B_USED;
			end
			if (take && win[3]) begin
				irq_ctrl_reg_b[mic_pkg::B_BUS_FLAG] <= 1'b0;
			end
			if (bus_evt) begin
				irq_ctrl_reg_b[mic_pkg::B_BUS_FLAG] <= 1'b1;
			end
		end
	end

	// Core side: push request and vector; no status is ever saved
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_ack    <= 1'b0;
			irq_vector <= '0;
		end else begin
			irq_ack <= take;
			if (take) begin
				unique case (1'b1)
					win[0]: irq_vector <= mic_pkg::VEC_EXT;
					win[1]: irq_vector <= mic_pkg::VEC_TMR;
					win[2]: irq_vector <= mic_pkg::VEC_ADC;
					win[3]: irq_vector <= mic_pkg::VEC_BUS;
				endcase
			end
		end
	end

	// Wake ignores the global enable so a halted core restarts on any enabled source
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wake_req <= 1'b0;
		end else begin
			wake_req <= |req;
		end
	end

	// Sticky status; a read clears it, but a new event in that cycle survives
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_stat <= '0;
			irq_mask <= mic_pkg::MASK_RST;
			irq      <= 1'b0;
		end else begin
			irq_stat <= (irq_stat & {4{~rd_clr_stat}})
				| {bus_evt, ext_edge, stall, take};
			if (wr_mask) begin
				irq_mask <= wr_data[3:0];
			end
			irq <= |(irq_stat & irq_mask);
		end
	end

	// Write channel: address and data taken in any order, response after both
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= mic_pkg::RESP_OKAY;
			wr_addr       <= '0;
			wr_data       <= '0;
			wr_strb       <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				wr_addr       <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				wr_data      <= s_axi_wdata;
				wr_strb      <= s_axi_wstrb;
			end
			if (wr_do) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_a || wr_b || wr_mask
					|| wr_addr == mic_pkg::mic_addr(mic_pkg::IRQ_STAT_IDX)
					|| wr_addr == mic_pkg::mic_addr(mic_pkg::CORE_STAT_IDX)
					|| wr_strb[0] == 1'b0) ? mic_pkg::RESP_OKAY : mic_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Status registers ignore writes; only byte lane 0 carries data
	assign wr_do   = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
	assign wr_a    = wr_do & wr_strb[0] & (wr_addr == mic_pkg::mic_addr(mic_pkg::REG_A_IDX));
	assign wr_b    = wr_do & wr_strb[0] & (wr_addr == mic_pkg::mic_addr(mic_pkg::REG_B_IDX));
	assign wr_mask = wr_do & wr_strb[0] & (wr_addr == mic_pkg::mic_addr(mic_pkg::IRQ_MASK_IDX));

	// Read decode
	always_comb begin
		next_rdata = '0;
		next_rd_ok = 1'b1;
		if (s_axi_araddr == mic_pkg::mic_addr(mic_pkg::REG_A_IDX)) begin
			next_rdata[7:0] = irq_ctrl_reg_a;
		end else if (s_axi_araddr == mic_pkg::mic_addr(mic_pkg::REG_B_IDX)) begin
			next_rdata[7:0] = irq_ctrl_reg_b;
		end else if (s_axi_araddr == mic_pkg::mic_addr(mic_pkg::IRQ_STAT_IDX)) begin
			next_rdata[3:0] = irq_stat;
		end else if (s_axi_araddr == mic_pkg::mic_addr(mic_pkg::IRQ_MASK_IDX)) begin
			next_rdata[3:0] = irq_mask;
		end else if (s_axi_araddr == mic_pkg::mic_addr(mic_pkg::CORE_STAT_IDX)) begin
			next_rdata[15:0] = {irq_vector[7:0], 4'h0, stack_full, stack_level_index};
		end else begin
			next_rd_ok = 1'b0;
		end
	end

	assign rd_take     = s_axi_arvalid & s_axi_arready;
	assign rd_clr_stat = rd_take & (s_axi_araddr == mic_pkg::mic_addr(mic_pkg::IRQ_STAT_IDX));

	// Read channel: one read in flight, data one cycle after the address
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= mic_pkg::RESP_OKAY;
		end else if (rd_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rd_ok ? mic_pkg::RESP_OKAY : mic_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Checks on the service path
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_take_ext;
		take && win[0];
	endsequence
	sequence s_take_bus;
		take && win[3];
	endsequence

	a_gie_cleared: assert property (take && !wr_a && !irq_exit_reenable
		|=> !irq_ctrl_reg_a[mic_pkg::A_GIE]) else $error("global enable kept after service");
	a_full_no_ack: assert property (stack_full |=> !irq_ack)
		else $error("acknowledge while stack full");
	a_edge_sets_flag: assert property (ext_edge |=> irq_ctrl_reg_a[mic_pkg::A_EXT_FLAG])
		else $error("falling edge lost");
	a_ext_vector: assert property (s_take_ext ##1 irq_ack
		|-> irq_vector == mic_pkg::VEC_EXT) else $error("wrong external vector");
	a_bus_service: assert property (s_take_bus |=> irq_ack && irq_vector == mic_pkg::VEC_BUS
		&& (irq_ctrl_reg_b[mic_pkg::B_BUS_FLAG] == $past(bus_evt)))
		else $error("bus service wrong");
	a_tmr_priority: assert property (take && req[1] && !req[0]
		|=> irq_vector == mic_pkg::VEC_TMR) else $error("timer priority wrong");
	a_irq_exit_reenable_enable: assert property (irq_exit_reenable |=> irq_ctrl_reg_a[mic_pkg::A_GIE])
		else $error("interrupt return left enable off");
	a_ret_keeps: assert property (subroutine_exit && !irq_exit_reenable && !take && !wr_a
		|=> $stable(irq_ctrl_reg_a[mic_pkg::A_GIE])) else $error("plain return changed enable");
	a_ack_on_phase: assert property (irq_ack |-> $past(phase_two_pulse))
		else $error("acknowledge off phase two");
	a_wake_follows: assert property ((|req) |=> wake_req)
		else $error("no wake on pending source");

	// A serviced flag drops unless its own event lands in that same cycle
	a_ext_cleared: assert property (take && win[0] && !ext_edge
		|=> !irq_ctrl_reg_a[mic_pkg::A_EXT_FLAG])
		else $error("external flag kept after service");
	a_tmr_cleared: assert property (take && win[1] && !timer_overflow
		|=> !irq_ctrl_reg_a[mic_pkg::A_TMR_FLAG])
		else $error("timer flag kept after service");
	a_adc_cleared: assert property (take && win[2] && !adc_done
		|=> !irq_ctrl_reg_a[mic_pkg::A_ADC_FLAG])
		else $error("converter flag kept after service");
	a_flag_holds: assert property (irq_ctrl_reg_a[mic_pkg::A_TMR_FLAG]
		&& !take && !wr_a |=> irq_ctrl_reg_a[mic_pkg::A_TMR_FLAG])
		else $error("timer flag dropped while pending");
	a_bus_flag_set: assert property (bus_evt
		|=> irq_ctrl_reg_b[mic_pkg::B_BUS_FLAG])
		else $error("bus event lost");

	// Register B shape, wake release, refusal record and the level output
	a_reg_b_shape: assert property (
		(irq_ctrl_reg_b & ~mic_pkg::REG_B_USED) == 8'h00)
		else $error("unused register B bit set");
	a_wake_idle: assert property (!(|req)
		|=> !wake_req)
		else $error("wake without pending source");
	a_stall_status: assert property (stall
		|=> irq_stat[mic_pkg::ST_STALL])
		else $error("refused service not recorded");
	a_irq_level: assert property ((|(irq_stat & irq_mask))
		|=> irq)
		else $error("interrupt output missed unmasked status");

endmodule

// file: mic_core_model.sv
// Behavioural model of the core sequencer facing the interrupt controller.
// Assumes the bench pulses do_call, do_irq_exit_reenable and do_ret for one clock each.
`timescale 1ns/1ps
module mic_core_model #(
	parameter int DEPTH = 6
) (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       irq_ack,
	input  wire logic       do_call,
	input  wire logic       do_irq_exit_reenable,
	input  wire logic       do_ret,
	output logic            phase_two_pulse,
	output logic [2:0]      stack_level_index,
	output logic            irq_exit_reenable,
	output logic            subroutine_exit
);
	logic [1:0] phase;

	// One second-phase pulse every four clocks, like an instruction cycle
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			phase <= 2'h0;
			phase_two_pulse <= 1'b0;
		end else begin
			phase <= phase + 2'h1;
			phase_two_pulse <= (phase == 2'h3);
		end
	end

	// Push on acknowledge or call; a push when full is dropped and the level stays at DEPTH
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			stack_level_index <= 3'h0;
		end else if ((irq_ack || do_call) && stack_level_index != 3'(DEPTH)) begin
			stack_level_index <= stack_level_index + 3'h1;
		end else if ((do_irq_exit_reenable || do_ret) && stack_level_index != 3'h0) begin
			stack_level_index <= stack_level_index - 3'h1;
		end
	end

	// Return strobes follow the bench's command one clock later
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_exit_reenable <= 1'b0;
			subroutine_exit <= 1'b0;
		end else begin
			irq_exit_reenable <= do_irq_exit_reenable;
			subroutine_exit <= do_ret;
		end
	end
endmodule

// file: mcu_interrupt_controller_test.sv
// Self-checking bench for the interrupt controller over its register bus.
// Assumes the core model drives the sequencer side; the bench fires events.
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module mcu_interrupt_controller_test;
	localparam logic [11:0] A_AD = 12'h02C, B_AD = 12'h078, ST_AD = 12'h0C0, MK_AD = 12'h0C4;
	logic        clock = 1'b0, rst = 1'b1;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic        s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, ext_irq_pin_n = 1, timer_overflow = 0, adc_done = 0;
	logic        addr_match_flag = 0, bus_byte_done = 0, do_call = 0, do_irq_exit_reenable = 0, do_ret = 0;
	logic        phase_two_pulse, irq_exit_reenable, subroutine_exit, irq_ack, wake_req, irq, got;
	logic [2:0]  stack_level_index;
	logic [10:0] irq_vector, vec;
	int          err_total = 0, check_count = 0;

	always #20 clock = ~clock;

	mic_intc #(.STACK_DEPTH(6)) mic_intc_i (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_irq_pin_n, .timer_overflow, .adc_done,
		.addr_match_flag, .bus_byte_done, .phase_two_pulse, .stack_level_index, .irq_exit_reenable,
		.subroutine_exit, .irq_ack, .irq_vector, .wake_req, .irq);
	mic_core_model #(.DEPTH(6)) mic_core_model_i (.clock, .rst, .irq_ack, .do_call, .do_irq_exit_reenable,
		.do_ret, .phase_two_pulse, .stack_level_index, .irq_exit_reenable, .subroutine_exit);

	// Write one register; each channel is released at its own handshake
	task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic [1:0] er);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, v};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		forever begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		`CHK(s_axi_bresp, er)
	endtask

	task automatic rd(input logic [11:0] a, input logic [1:0] er);
		@(posedge clock);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		forever begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		d = s_axi_rdata;
		s_axi_rready <= 1'b0;
		`CHK(s_axi_rresp, er)
	endtask

	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		rd(a, 2'h0);
		`CHK(d, e)
	endtask

	// Watch for an acknowledge; the vector is valid in the same cycle
	task automatic wack(input int lim);
		got = 1'b0;
		repeat (lim) begin
			@(posedge clock);
			if (irq_ack === 1'b1) begin
				got = 1'b1;
				vec = irq_vector;
				break;
			end
		end
	endtask

	// Bit 0 drops the pin, others pulse timer, converter, match and byte events
	task automatic ev(input logic [4:0] m);
		@(posedge clock);
		ext_irq_pin_n <= ~m[0];
		{bus_byte_done, addr_match_flag, adc_done, timer_overflow} <= m[4:1];
		@(posedge clock);
		{bus_byte_done, addr_match_flag, adc_done, timer_overflow} <= 4'h0;
		repeat (3) @(posedge clock);
		ext_irq_pin_n <= 1'b1;
		repeat (2) @(posedge clock);
	endtask

	// Bits: call, interrupt return, plain return
	task automatic cmd(input logic [2:0] c);
		@(posedge clock);
		{do_ret, do_irq_exit_reenable, do_call} <= c;
		@(posedge clock);
		{do_ret, do_irq_exit_reenable, do_call} <= 3'h0;
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// Hang guard, far beyond the few hundred clocks the tests need
	initial begin
		repeat (20000) @(posedge clock);
		err_total++;
		test_done();
	end

	initial begin
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		rc(A_AD, 32'h0);
		rc(B_AD, 32'h0);
		wr(B_AD, 8'hFF, 2'h0);
		rc(B_AD, 32'h11);
		wr(B_AD, 8'h00, 2'h0);
		rd(12'h100, 2'h2);
		wr(12'h100, 8'h01, 2'h2);
		wr(ST_AD, 8'h0F, 2'h0);
		rc(ST_AD, 32'h0);
		wr(MK_AD, 8'h01, 2'h0);
		`CHK(irq, 1'b0)
		$display("test registers done");
		// Each source alone; bit 7 always written as zero
		for (int s = 0; s < 4; s++) begin
			wr(B_AD, 8'(s == 3), 2'h0);
			wr(A_AD, 8'h01 | ((s < 3) ? 8'(2 << s) : 8'h00), 2'h0);
			fork
				ev(5'(1 << s));
				wack(12);
			join
			`CHK(got, 1'b1)
			`CHK(vec, 11'(4 * (s + 1)))
			rc(A_AD, (s < 3) ? (2 << s) : 0);
			rc(B_AD, 32'(s == 3));
			`CHK(irq, 1'b1)
			rc(ST_AD, 1 | ((s == 0) ? 4 : 0) | ((s == 3) ? 8 : 0));
			repeat (2) @(posedge clock);
			`CHK(irq, 1'b0)
			cmd(3'h2);
			repeat (2) @(posedge clock);
			rc(A_AD, ((s < 3) ? (2 << s) : 0) | 1);
			wr(A_AD, 8'h00, 2'h0);
		end
		$display("test sources done");
		// All four at once while masked globally, then serviced in order
		wr(A_AD, 8'h0E, 2'h0);
		ev(5'h17);
		rc(A_AD, 32'h7E);
		rc(B_AD, 32'h11);
		`CHK(wake_req, 1'b1)
		for (int k = 0; k < 4; k++) begin
			fork
				if (k == 0) wr(A_AD, 8'h7F, 2'h0); else cmd(3'h2);
				wack(16);
			join
			`CHK(got, 1'b1)
			`CHK(vec, 11'(4 * (k + 1)))
		end
		cmd(3'h2);
		wr(A_AD, 8'h00, 2'h0);
		$display("test priority done");
		// Full stack holds off service until a plain return pops it
		wr(MK_AD, 8'h00, 2'h0);
		repeat (6) cmd(3'h1);
		fork
			wr(A_AD, 8'h25, 2'h0);
			wack(16);
		join
		`CHK(got, 1'b0)
		rc(12'h0C8, 32'h100E);
		rc(ST_AD, 32'h0F);
		fork
			cmd(3'h4);
			wack(16);
		join
		`CHK(got, 1'b1)
		`CHK(vec, 11'h008)
		`CHK(irq, 1'b0)
		repeat (6) cmd(3'h4);
		rc(A_AD, 32'h04);
		$display("test stack done");
		test_done();
	end
endmodule
